/* File: design/dsfl_pkg.sv */
package dsfl_pkg;
    // Register byte offsets on the APB window.
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_CLAMP  = 8'h08;
    localparam logic [7:0] ADDR_ORIGIN = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS  = 8'h10;
    localparam logic [7:0] ADDR_FAULT  = 8'h14;
    localparam logic [7:0] ADDR_POS    = 8'h18;
    localparam logic [7:0] ADDR_ISTAT  = 8'h1C;
    localparam logic [7:0] ADDR_IMASK  = 8'h20;
    localparam logic [7:0] ADDR_CURR   = 8'h24;

    // Width of current figures in percent of system rated current.
    localparam int CUR_W = 16;
    localparam int POS_W = 32;

    // Control register field and reset values.
    localparam int CTRL_CLAMP_ON_BIT = 0;
    localparam logic [CUR_W-1:0] THRESH_RST = 16'h0064;
    localparam logic [CUR_W-1:0] CLAMP_RST  = 16'h0064;
    localparam logic [POS_W-1:0] ORIGIN_RST = 32'h0000_0000;

    // Flags register bit positions.
    localparam int FLG_THR    = 0;
    localparam int FLG_CLAMP  = 1;
    localparam int FLG_DECEL  = 2;
    localparam int FLG_ORIGIN = 3;
    localparam int FLG_BRIDGE = 4;
    localparam int FLG_NOTRIP = 5;
    localparam int FLG_CLEAR  = 6;
    localparam int FLG_POWER  = 7;
    localparam int FLG_W      = 8;

    // Fault bitmap bit positions.
    localparam int FB_WDOG   = 0;
    localparam int FB_CFG    = 1;
    localparam int FB_NVM    = 2;
    localparam int FB_POST   = 3;
    localparam int FB_FOLLOW = 4;
    localparam int FB_LIMP   = 5;
    localparam int FB_LIMN   = 6;
    localparam int FB_PROG   = 7;
    localparam int FB_NOPROG = 8;
    localparam int FB_TRAJ   = 12;
    localparam int FB_PARAM  = 13;
    localparam int FB_TEMP   = 15;
    localparam int FB_OVRUN  = 16;
    localparam int FB_SHORT  = 17;
    localparam logic [31:0] FB_LIMIT_MASK = 32'h0000_0060;

    // Interrupt status bit positions; the mask uses the same layout.
    localparam int IRQ_THR    = 0;
    localparam int IRQ_CLAMP  = 1;
    localparam int IRQ_ORIGIN = 2;
    localparam int IRQ_TRIP   = 3;
    localparam int IRQ_FAULT  = 4;
    localparam int IRQ_W      = 5;

    // Profile segment state, one-hot.
    typedef enum logic [3:0] {
        SEG_IDLE   = 4'b0001,
        SEG_ACCEL  = 4'b0010,
        SEG_CRUISE = 4'b0100,
        SEG_DECEL  = 4'b1000
    } dsfl_seg_type;

    // Fault sources reported by the module.
    typedef struct packed {
        logic wdog;
        logic cfg;
        logic nvm;
        logic post;
        logic follow;
        logic limp;
        logic limn;
        logic prog;
        logic noprog;
        logic traj;
        logic param;
        logic temp;
        logic ovrun;
        logic short_out;
    } dsfl_fault_type;

    // Everything arriving from the drive and the trajectory generator.
    typedef struct packed {
        logic [CUR_W-1:0] cur_req;
        logic             traj_tick;
        logic             bridge;
        logic             trip;
        logic             enabled;
        logic             origin_strobe;
        logic             idx_busy;
        logic             idx_accel;
        logic             idx_decel;
        logic             idx_last;
        dsfl_fault_type   fault;
    } dsfl_drive_in_type;
endpackage : dsfl_pkg

/* File: design/dsfl_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: Load current request comes from drive parameter 4.04, percent of rated.
// RULE_02: Threshold flag sets when request is at or above threshold.
// RULE_03: Threshold flag clears once request falls below threshold.
// RULE_04: Clamp flag sets when request is at or above clamp value.
// RULE_05: Clamp flag clears once request drops below clamp value.
// RULE_06: Output current clamped only while clamp enable is on; reset off.
// RULE_07: Index runs accelerate, cruise, decelerate; decel flag only in last.
// RULE_08: In compounded indexes only the last may decelerate.
// RULE_09: Origin strobe rising edge loads commanded position, sets valid.
// RULE_10: Bridge flag copies drive parameter 10.02, cleared by a trip.
// RULE_11: No-trip flag high without trip, low during trip.
// RULE_12: All-clear low on any fault or trip except travel limits.
// RULE_13: Power stage flag follows drive enable.
// RULE_14: Fault bits 0 to 4: watchdog, config, memory, self test, following.
// RULE_15: Fault bits 5 and 6 follow positive and negative travel limits.
// RULE_16: Fault bits 7, 8, 12, 13: program, no program, trajectory, param.
// RULE_17: Fault bits 15, 16, 17: overtemp, update overrun, shorted output.
// RULE_18: Unused fault bitmap positions read as zero.
// RULE_19: Both current comparisons re-evaluated at each trajectory update.
module dsfl_top (
    // APB clock and reset.
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave.
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    // Drive and trajectory pins, asynchronous to pclk.
    input  wire dsfl_pkg::dsfl_drive_in_type drive_in,
    // Drive commands and status.
    output logic [dsfl_pkg::CUR_W-1:0]     current_cmd,
    output logic [dsfl_pkg::POS_W-1:0]     commanded_pos,
    output logic [dsfl_pkg::FLG_W-1:0]     flags,
    output logic [31:0]                    fault_bitmap,
    output logic                           irq
);
    // Compare helper shared by both current monitors.
    function automatic logic at_or_above(
        input logic [dsfl_pkg::CUR_W-1:0] a,
        input logic [dsfl_pkg::CUR_W-1:0] b
    );
        at_or_above = (a >= b);
    endfunction : at_or_above

    dsfl_pkg::dsfl_drive_in_type sync1_reg;
    dsfl_pkg::dsfl_drive_in_type din;
    logic                         tick_d_reg;
    logic                         strobe_d_reg;
    logic                         clamp_on_reg;
    logic [dsfl_pkg::CUR_W-1:0]   thresh_reg;
    logic [dsfl_pkg::CUR_W-1:0]   clamp_reg;
    logic [dsfl_pkg::POS_W-1:0]   origin_reg;
    logic [dsfl_pkg::CUR_W-1:0]   cur_reg;
    logic                         thr_hit_reg;
    logic                         clamp_hit_reg;
    logic                         origin_valid_reg;
    logic [dsfl_pkg::IRQ_W-1:0]   istat_reg;
    logic [dsfl_pkg::IRQ_W-1:0]   imask_reg;
    logic [dsfl_pkg::IRQ_W-1:0]   ievent;
    logic                         trip_d_reg;
    logic                         fault_d_reg;
    logic                         tick_rise;
    logic                         strobe_rise;
    logic                         wr_en;
    logic                         rd_en;
    logic                         addr_ok;
    logic [31:0]                  fault_next;
    logic [dsfl_pkg::FLG_W-1:0]   flags_next;
    dsfl_pkg::dsfl_seg_type       seg_reg;
    dsfl_pkg::dsfl_seg_type       seg_next;

    // Two-stage synchroniser for every pin; the first stage feeds only
    // the second. Multi-bit current may tear for one sample, which the
    // next trajectory tick repairs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            din       <= '0;
        end else begin
            sync1_reg <= drive_in;
            din       <= sync1_reg;
        end
    end

    // Edge detectors on the synchronised tick, origin strobe, trip and non-limit fault summary.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_d_reg   <= 1'b0;
            strobe_d_reg <= 1'b0;
            trip_d_reg   <= 1'b0;
            fault_d_reg  <= 1'b0;
        end else begin
            tick_d_reg   <= din.traj_tick;
            strobe_d_reg <= din.origin_strobe;
            trip_d_reg   <= din.trip;
            fault_d_reg  <= |(fault_next & ~dsfl_pkg::FB_LIMIT_MASK);
        end
    end

    assign tick_rise   = din.traj_tick & ~tick_d_reg;
    assign strobe_rise = din.origin_strobe & ~strobe_d_reg; // RULE_09

    // APB decode. One wait state gives time to register read data.
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready & ~pwrite;
    always_comb begin
        case (paddr)
            dsfl_pkg::ADDR_CTRL,   dsfl_pkg::ADDR_THRESH,
            dsfl_pkg::ADDR_CLAMP,  dsfl_pkg::ADDR_ORIGIN,
            dsfl_pkg::ADDR_FLAGS,  dsfl_pkg::ADDR_FAULT,
            dsfl_pkg::ADDR_POS,    dsfl_pkg::ADDR_ISTAT,
            dsfl_pkg::ADDR_IMASK,  dsfl_pkg::ADDR_CURR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Ready and error answer in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
        end
    end

    // Read data is captured on the same edge that raises pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                dsfl_pkg::ADDR_CTRL:   prdata <= {31'h0, clamp_on_reg};
                dsfl_pkg::ADDR_THRESH: prdata <= {16'h0, thresh_reg};
                dsfl_pkg::ADDR_CLAMP:  prdata <= {16'h0, clamp_reg};
                dsfl_pkg::ADDR_ORIGIN: prdata <= origin_reg;
                dsfl_pkg::ADDR_FLAGS:  prdata <= {24'h0, flags};
                dsfl_pkg::ADDR_FAULT:  prdata <= fault_bitmap;
                dsfl_pkg::ADDR_POS:    prdata <= commanded_pos;
                dsfl_pkg::ADDR_ISTAT:  prdata <= {27'h0, istat_reg};
                dsfl_pkg::ADDR_IMASK:  prdata <= {27'h0, imask_reg};
                dsfl_pkg::ADDR_CURR:   prdata <= {16'h0, cur_reg};
                default:               prdata <= 32'h0000_0000;
            endcase
        end else if (!psel) begin
            prdata <= 32'h0000_0000;
        end
    end

    // Software settings. Clamp enable is off out of reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clamp_on_reg <= 1'b0; // RULE_06
            thresh_reg   <= dsfl_pkg::THRESH_RST;
            clamp_reg    <= dsfl_pkg::CLAMP_RST;
            origin_reg   <= dsfl_pkg::ORIGIN_RST;
            imask_reg    <= '0;
        end else if (wr_en) begin
            case (paddr)
                dsfl_pkg::ADDR_CTRL:
                    clamp_on_reg <= pwdata[dsfl_pkg::CTRL_CLAMP_ON_BIT];
                dsfl_pkg::ADDR_THRESH:
                    thresh_reg <= pwdata[dsfl_pkg::CUR_W-1:0];
                dsfl_pkg::ADDR_CLAMP:
                    clamp_reg <= pwdata[dsfl_pkg::CUR_W-1:0];
                dsfl_pkg::ADDR_ORIGIN:
                    origin_reg <= pwdata;
                dsfl_pkg::ADDR_IMASK:
                    imask_reg <= pwdata[dsfl_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Current sampled and both limits compared once per update tick, so
    // the flags move only at trajectory update boundaries.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg       <= '0;
            thr_hit_reg   <= 1'b0;
            clamp_hit_reg <= 1'b0;
        end else if (tick_rise) begin // RULE_19
            cur_reg       <= din.cur_req; // RULE_01
            thr_hit_reg   <= at_or_above(din.cur_req, thresh_reg); // RULE_02
            clamp_hit_reg <= at_or_above(din.cur_req, clamp_reg); // RULE_04
        end
    end

    // Current command to the power stage, limited only when enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_cmd <= '0;
        end else if (clamp_on_reg && at_or_above(cur_reg, clamp_reg)) begin
            current_cmd <= clamp_reg; // RULE_06
        end else begin
            current_cmd <= cur_reg;
        end
    end

    // Origin load. Valid stays set once any origin has been defined.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            commanded_pos    <= '0;
            origin_valid_reg <= 1'b0;
        end else if (strobe_rise) begin
            commanded_pos    <= origin_reg; // RULE_09
            origin_valid_reg <= 1'b1; // RULE_09
        end
    end

    // Profile segments. Cruise moves to decel only for the last index of
    // a compound profile, so earlier indexes never show a decel phase.
    always_comb begin
        seg_next = seg_reg;
        case (seg_reg)
            dsfl_pkg::SEG_IDLE:
                if (din.idx_busy && din.idx_accel)
                    seg_next = dsfl_pkg::SEG_ACCEL;
            dsfl_pkg::SEG_ACCEL:
                if (!din.idx_busy)
                    seg_next = dsfl_pkg::SEG_IDLE;
                else if (!din.idx_accel)
                    seg_next = dsfl_pkg::SEG_CRUISE; // RULE_07
            dsfl_pkg::SEG_CRUISE:
                if (!din.idx_busy)
                    seg_next = dsfl_pkg::SEG_IDLE;
                else if (din.idx_decel && din.idx_last)
                    seg_next = dsfl_pkg::SEG_DECEL; // RULE_08
            dsfl_pkg::SEG_DECEL:
                if (!din.idx_busy)
                    seg_next = dsfl_pkg::SEG_IDLE;
            default: seg_next = dsfl_pkg::SEG_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_reg <= dsfl_pkg::SEG_IDLE;
        end else begin
            seg_reg <= seg_next;
        end
    end

    // Fault bitmap packing; unused positions stay zero.
    always_comb begin
        fault_next = 32'h0000_0000; // RULE_18
        fault_next[dsfl_pkg::FB_WDOG]   = din.fault.wdog; // RULE_14
        fault_next[dsfl_pkg::FB_CFG]    = din.fault.cfg;
        fault_next[dsfl_pkg::FB_NVM]    = din.fault.nvm;
        fault_next[dsfl_pkg::FB_POST]   = din.fault.post;
        fault_next[dsfl_pkg::FB_FOLLOW] = din.fault.follow;
        fault_next[dsfl_pkg::FB_LIMP]   = din.fault.limp; // RULE_15
        fault_next[dsfl_pkg::FB_LIMN]   = din.fault.limn;
        fault_next[dsfl_pkg::FB_PROG]   = din.fault.prog; // RULE_16
        fault_next[dsfl_pkg::FB_NOPROG] = din.fault.noprog;
        fault_next[dsfl_pkg::FB_TRAJ]   = din.fault.traj;
        fault_next[dsfl_pkg::FB_PARAM]  = din.fault.param;
        fault_next[dsfl_pkg::FB_TEMP]   = din.fault.temp; // RULE_17
        fault_next[dsfl_pkg::FB_OVRUN]  = din.fault.ovrun;
        fault_next[dsfl_pkg::FB_SHORT]  = din.fault.short_out;
    end

    // Status flags, all registered off synchronised inputs.
    always_comb begin
        flags_next = '0;
        flags_next[dsfl_pkg::FLG_THR]    = thr_hit_reg;
        flags_next[dsfl_pkg::FLG_CLAMP]  = clamp_hit_reg;
        flags_next[dsfl_pkg::FLG_DECEL]  =
            (seg_next == dsfl_pkg::SEG_DECEL); // RULE_07
        flags_next[dsfl_pkg::FLG_ORIGIN] = origin_valid_reg;
        flags_next[dsfl_pkg::FLG_BRIDGE] = din.bridge & ~din.trip; // RULE_10
        flags_next[dsfl_pkg::FLG_NOTRIP] = ~din.trip; // RULE_11
        flags_next[dsfl_pkg::FLG_CLEAR]  = ~din.trip &
            ~|(fault_next & ~dsfl_pkg::FB_LIMIT_MASK); // RULE_12
        flags_next[dsfl_pkg::FLG_POWER]  = din.enabled; // RULE_13
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags        <= '0;
            fault_bitmap <= 32'h0000_0000;
        end else begin
            flags        <= flags_next;
            fault_bitmap <= fault_next;
        end
    end

    // Interrupt events are rising edges of the interesting conditions.
    assign ievent[dsfl_pkg::IRQ_THR]    =
        flags_next[dsfl_pkg::FLG_THR] & ~flags[dsfl_pkg::FLG_THR];
    assign ievent[dsfl_pkg::IRQ_CLAMP]  =
        flags_next[dsfl_pkg::FLG_CLAMP] & ~flags[dsfl_pkg::FLG_CLAMP];
    assign ievent[dsfl_pkg::IRQ_ORIGIN] = strobe_rise;
    assign ievent[dsfl_pkg::IRQ_TRIP]   = din.trip & ~trip_d_reg;
    assign ievent[dsfl_pkg::IRQ_FAULT]  =
        |(fault_next & ~dsfl_pkg::FB_LIMIT_MASK) & ~fault_d_reg;

    // Sticky status, write one to clear; a new event beats the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= '0;
        end else if (wr_en && paddr == dsfl_pkg::ADDR_ISTAT) begin
            istat_reg <= (istat_reg & ~pwdata[dsfl_pkg::IRQ_W-1:0]) | ievent;
        end else begin
            istat_reg <= istat_reg | ievent;
        end
    end

    // Level interrupt, registered so it comes straight from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_reg & imask_reg);
        end
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    thr_set_a: assert property (
        tick_rise && din.cur_req >= thresh_reg
        |=> thr_hit_reg ##1 flags[dsfl_pkg::FLG_THR]) // RULE_02
        else $error("threshold flag not set");

    thr_clear_a: assert property (
        tick_rise && din.cur_req < thresh_reg
        |=> !thr_hit_reg ##1 !flags[dsfl_pkg::FLG_THR]) // RULE_03
        else $error("threshold flag not cleared");

    clamp_set_a: assert property (
        tick_rise && din.cur_req >= clamp_reg |=> clamp_hit_reg) // RULE_04
        else $error("clamp flag not set");

    clamp_clear_a: assert property (
        tick_rise && din.cur_req < clamp_reg |=> !clamp_hit_reg) // RULE_05
        else $error("clamp flag not cleared");

    clamp_limit_a: assert property (
        ##1 !$past(clamp_on_reg) |-> current_cmd == $past(cur_reg)) // RULE_06
        else $error("current limited while clamp off");

    compare_hold_a: assert property (
        !tick_rise |=> $stable(thr_hit_reg) && $stable(clamp_hit_reg)) // RULE_19
        else $error("comparison moved between ticks");

    decel_last_a: assert property (
        seg_reg == dsfl_pkg::SEG_CRUISE && !din.idx_last
        |=> !flags[dsfl_pkg::FLG_DECEL]) // RULE_08
        else $error("decel shown for non-last index");

    decel_order_a: assert property (
        seg_reg == dsfl_pkg::SEG_DECEL
        |-> $past(seg_reg) inside {dsfl_pkg::SEG_CRUISE,
                                   dsfl_pkg::SEG_DECEL}) // RULE_07
        else $error("decel entered out of order");

    origin_load_a: assert property (
        strobe_rise |=> commanded_pos == $past(origin_reg)
        && origin_valid_reg) // RULE_09
        else $error("origin not loaded on strobe");

    bridge_trip_a: assert property (
        din.trip |=> !flags[dsfl_pkg::FLG_BRIDGE]
        && !flags[dsfl_pkg::FLG_NOTRIP]) // RULE_10
        else $error("bridge or no-trip flag during trip");

    no_trip_a: assert property (
        $fell(din.trip) |=> flags[dsfl_pkg::FLG_NOTRIP]) // RULE_11
        else $error("no-trip flag not restored");

    all_clear_a: assert property (
        !din.trip && fault_next == (fault_next & dsfl_pkg::FB_LIMIT_MASK)
        |=> flags[dsfl_pkg::FLG_CLEAR]) // RULE_12
        else $error("all-clear dropped by limit or enable");

    power_stage_a: assert property (
        ##1 flags[dsfl_pkg::FLG_POWER] == $past(din.enabled)) // RULE_13
        else $error("power stage flag wrong");

    fault_pack_a: assert property (
        ##1 fault_bitmap[dsfl_pkg::FB_LIMN] == $past(din.fault.limn)
        && fault_bitmap[dsfl_pkg::FB_WDOG] == $past(din.fault.wdog)
        && fault_bitmap[dsfl_pkg::FB_SHORT]
           == $past(din.fault.short_out)) // RULE_14
        else $error("fault bitmap packing wrong");

    unused_zero_a: assert property (
        (fault_bitmap & 32'hFFFC_4E00) == 32'h0000_0000) // RULE_18
        else $error("unused fault bit set");
endmodule : dsfl_top
`default_nettype wire

/* File: tb/dsfl_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsfl_drive_model (
    // Clock that paces the drive pins.
    input  wire logic                        pclk,
    // Pins seen by the block; the bench sets slow levels by name.
    output var  dsfl_pkg::dsfl_drive_in_type drive_in
);
    // The drive starts quiet, with no trip, fault or motion.
    initial begin
        drive_in = '0;
    end

    // Demand is in percent of rated current and is held across a tick.
    task automatic tick(input logic [15:0] c);
        @(posedge pclk);
        drive_in.cur_req   <= c;
        drive_in.traj_tick <= 1'b1;
        repeat (3) @(posedge pclk);
        drive_in.traj_tick <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : tick
endmodule : dsfl_drive_model
`default_nettype wire

/* File: tb/dsfl_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dsfl_top_tb;
    logic                        pclk;
    logic                        presetn;
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [7:0]                  paddr;
    logic [31:0]                 pwdata;
    logic                        pready;
    logic [31:0]                 prdata;
    logic                        pslverr;
    logic [15:0]                 current_cmd;
    logic [31:0]                 commanded_pos;
    logic [7:0]                  flags;
    logic [31:0]                 fault_bitmap;
    logic                        irq;
    dsfl_pkg::dsfl_drive_in_type drive_in;
    int                          error_cnt;
    int                          tests_run;
    int                          seed;
    logic [31:0]                 rd;
    logic                        err;

    dsfl_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .drive_in, .current_cmd,
        .commanded_pos, .flags, .fault_bitmap, .irq);
    dsfl_drive_model dm (.pclk, .drive_in);

    // Free-running bus clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // One bus transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        if (n >= 20) error_cnt++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Compares one seen value with the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // A hung handshake must not stall the run forever.
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end

    // Main sequence; expectations come from integer arithmetic here.
    initial begin
        int c;
        int e;
        int pos[14];
        int bnd[4];
        pos = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 13, 15, 16, 17};
        bnd = '{49, 50, 79, 80};
        seed = 14;
        error_cnt = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(dsfl_pkg::ADDR_CTRL, 32'h0);
        rdc(dsfl_pkg::ADDR_THRESH, 32'h64);
        rdc(dsfl_pkg::ADDR_FAULT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        $display("Test reset done");
        apb(1'b1, dsfl_pkg::ADDR_THRESH, 32'h32);
        apb(1'b1, dsfl_pkg::ADDR_CLAMP, 32'h50);
        for (int i = 0; i < 12; i++) begin
            c = (i < 4) ? bnd[i] : ($random(seed) & 32'hFF);
            apb(1'b1, dsfl_pkg::ADDR_CTRL, 32'(i % 2));
            dm.tick(16'(c));
            repeat (2) @(posedge pclk);
            e = (i % 2 == 1 && c >= 80) ? 80 : c;
            chk(flags[0], c >= 50);
            chk(flags[1], c >= 80);
            chk(current_cmd, 16'(e));
            rdc(dsfl_pkg::ADDR_CURR, 32'(c));
        end
        // Edges are pending in the status but the mask is still clear.
        chk(irq, 1'b0);
        $display("Test current done");
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            dm.drive_in.bridge  <= i[2];
            dm.drive_in.trip    <= i[1];
            dm.drive_in.enabled <= i[0];
            repeat (5) @(posedge pclk);
            // Threshold and clamp bits still hold the last demand sent.
            rdc(dsfl_pkg::ADDR_FLAGS, 32'({i[0], {2{~i[1]}}, i[2] & ~i[1],
                2'b00, (c >= 80), (c >= 50)}));
            chk(flags[4], i[2] & ~i[1]);
            chk(flags[6:5], {2{~i[1]}});
            chk(flags[7], i[0]);
        end
        dm.drive_in.trip <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            @(posedge pclk);
            dm.drive_in.fault <= 14'(1 << (13 - i));
            repeat (5) @(posedge pclk);
            rdc(dsfl_pkg::ADDR_FAULT, 32'(1 << pos[i]));
            chk(fault_bitmap, 32'(1 << pos[i]));
            chk(flags[6], i == 5 || i == 6);
        end
        dm.drive_in.fault <= '0;
        $display("Test status done");
        dm.drive_in.idx_busy  <= 1'b1;
        dm.drive_in.idx_accel <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(flags[2], 1'b0);
        dm.drive_in.idx_accel <= 1'b0;
        dm.drive_in.idx_decel <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(flags[2], 1'b0);
        dm.drive_in.idx_last <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(flags[2], 1'b1);
        $display("Test profile done");
        c = $random(seed);
        apb(1'b1, dsfl_pkg::ADDR_ORIGIN, 32'(c));
        apb(1'b1, dsfl_pkg::ADDR_IMASK, 32'h4);
        dm.drive_in.origin_strobe <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(commanded_pos, 32'(c));
        chk({flags[3], irq}, 2'b11);
        apb(1'b1, dsfl_pkg::ADDR_ISTAT, 32'h4);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b0);
        // Threshold, clamp, trip and fault rises stay pending after the clear.
        rdc(dsfl_pkg::ADDR_ISTAT, 32'h0000_001B);
        rdc(dsfl_pkg::ADDR_POS, 32'(c));
        $display("Test origin done");
        give_verdict();
    end
endmodule : dsfl_top_tb
`default_nettype wire
